// *** src/timer_consts.svh ***
// constants for one timer channel: offsets, field codes, reset values
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
//
// Operation
// RL1 - select 000: software start only, hardware ignored
// RL2 - select 001: pin active edge starts and captures
// RL3 - select 010: one pin edge starts, other captures
// RL4 - select 100: slave starts on master interrupt
// RL5 - select 110: master starts, own pin edge ends
// RL6 - edge select 00 falling, 01 rising
// RL7 - edge select 10: start falling, capture rising
// RL8 - edge select 11: start rising, capture falling
// RL9 - capture mode counts upward
// RL10 - capture and one-count mode counts upward
// RL11 - option 1: interrupt and output change at start
// RL12 - option 0: no interrupt, no output change at start
// RL13 - option 0 one-count: triggers while counting ignored
// RL14 - option 1 one-count: retrigger restarts, no interrupt
// RL15 - output disabled: software level drives pin
// RL16 - output enabled: timer drives level, writes ignored
// RL17 - level bit 0 low, 1 high
// RL18 - start write 1 sets enable flag
// RL19 - stop write 1 clears enable flag
// RL20 - input pin synchronised, one pulse per edge
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define TMR_OFS_MODE_HIGH   6'h00
`define TMR_OFS_MODE_LOW    6'h04
`define TMR_OFS_OUT_ENABLE  6'h08
`define TMR_OFS_OUT_LEVEL   6'h0c
`define TMR_OFS_START       6'h10
`define TMR_OFS_STOP        6'h14
`define TMR_OFS_STATUS      6'h18
`define TMR_OFS_DATA        6'h1c
`define TMR_OFS_COUNT       6'h20

////////////////////////////////////////////////////////////////////////////////
// field positions
`define TMR_BIT_TRIG        0
`define TMR_STAT_ENABLE     0
`define TMR_STAT_COUNTING   1

////////////////////////////////////////////////////////////////////////////////
// start trigger select codes
`define TMR_STS_SOFT        3'h0
`define TMR_STS_PIN         3'h1
`define TMR_STS_BOTH        3'h2
`define TMR_STS_MASTER      3'h4
`define TMR_STS_MASTER_PIN  3'h6

// input edge select codes
`define TMR_CIS_FALL        2'h0
`define TMR_CIS_RISE        2'h1
`define TMR_CIS_LOW_WIDTH   2'h2
`define TMR_CIS_HIGH_WIDTH  2'h3

// operating mode codes, upper three mode bits
`define TMR_MD_INTERVAL     3'h0
`define TMR_MD_CAPTURE      3'h2
`define TMR_MD_EVENT        3'h3
`define TMR_MD_ONE_COUNT    3'h4
`define TMR_MD_CAP_ONE      3'h6

////////////////////////////////////////////////////////////////////////////////
// reset values
`define TMR_RST_MODE_HIGH   3'h0
`define TMR_RST_MODE_LOW    8'h00
`define TMR_RST_OUT_ENABLE  1'h0
`define TMR_RST_OUT_LEVEL   1'h0

`endif

// *** src/timer_pkg.sv ***
// types shared by the timer channel files
// assumes nothing beyond a systemverilog compiler
package timer_pkg;

    typedef struct packed {
        logic [1:0] edge_sel;
        logic [1:0] unused;
        logic [3:0] mode;
    } mode_cfg_type;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_evt_type;

    typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_COUNT} channel_state_type;

endpackage

// *** src/pin_edge_sync.sv ***
// two-flop synchroniser and edge detector for the timer input pin
// assumes the pin is asynchronous to core_clk
module pin_edge_sync
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // pin side
    input  wire logic                  pin_async,
    // core side
    output timer_pkg::edge_evt_type    edges
);

    logic meta;
    logic stable;
    logic prev;

    // first flop feeds only the second one
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
            edges  <= '0;
        end
        else
        begin
            meta       <= pin_async;
            stable     <= meta;
            prev       <= stable;
            edges.rise <= stable & ~prev;  // RL20
            edges.fall <= ~stable & prev;  // RL20
        end
    end

endmodule

// *** src/timer_channel.sv ***
// one timer channel: trigger selection, modes, output gating, avalon-mm registers
// assumes input pin asynchronous, master interrupt on core_clk, no prescaler
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`include "timer_consts.svh"
module timer_channel #(
    parameter int COUNT_WIDTH = 16
)
(
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // avalon-mm slave
    input  wire logic [5:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output      logic [31:0]             avs_readdata,
    output      logic                    avs_waitrequest,
    // pins and chaining
    input  wire logic                    timer_input_pin,
    input  wire logic                    master_interrupt_request,
    output      logic                    timer_output_pin,
    output      logic                    channel_interrupt_request
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [2:0]                    start_trigger_select;
    timer_pkg::mode_cfg_type       channel_mode_low;
    logic                          output_enable_bit;
    logic                          output_level_bit;
    logic [COUNT_WIDTH-1:0]        data_reg;
    logic [COUNT_WIDTH-1:0]        count_register;
    timer_pkg::channel_state_type  state;
    timer_pkg::edge_evt_type       pin_evt;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire logic wr_take    = avs_write & ~avs_waitrequest;
    wire logic lane0      = avs_byteenable[0];
    wire logic sel_mhigh  = avs_address == `TMR_OFS_MODE_HIGH;
    wire logic sel_mlow   = avs_address == `TMR_OFS_MODE_LOW;
    wire logic sel_oe     = avs_address == `TMR_OFS_OUT_ENABLE;
    wire logic sel_level  = avs_address == `TMR_OFS_OUT_LEVEL;
    wire logic sel_start  = avs_address == `TMR_OFS_START;
    wire logic sel_stop   = avs_address == `TMR_OFS_STOP;
    wire logic sel_status = avs_address == `TMR_OFS_STATUS;
    wire logic sel_data   = avs_address == `TMR_OFS_DATA;
    wire logic sel_count  = avs_address == `TMR_OFS_COUNT;

    wire logic wr_mhigh = wr_take & sel_mhigh & lane0;
    wire logic wr_mlow  = wr_take & sel_mlow & lane0;
    wire logic wr_oe    = wr_take & sel_oe & lane0;
    wire logic wr_level = wr_take & sel_level & lane0;
    wire logic wr_data  = wr_take & sel_data;
    wire logic sw_start = wr_take & sel_start & lane0 & avs_writedata[`TMR_BIT_TRIG];  // RL18
    wire logic sw_stop  = wr_take & sel_stop & lane0 & avs_writedata[`TMR_BIT_TRIG];   // RL19

    // byte lanes 0 and 1 of the data register
    wire logic [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire logic [COUNT_WIDTH-1:0] data_written =
        COUNT_WIDTH'((avs_writedata & be_mask) | (32'(data_reg) & ~be_mask));

    wire logic channel_enable_flag = state != timer_pkg::CH_IDLE;
    wire logic counting            = state == timer_pkg::CH_COUNT;

    wire logic [31:0] status_word = {30'h0, counting, channel_enable_flag};
    wire logic [31:0] rd_mux =
        sel_mhigh  ? 32'(start_trigger_select) :
        sel_mlow   ? 32'(channel_mode_low) :
        sel_oe     ? 32'(output_enable_bit) :
        sel_level  ? 32'(output_level_bit) :
        sel_status ? status_word :
        sel_data   ? 32'(data_reg) :
        sel_count  ? 32'(count_register) :
                     32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // input pin and trigger selection

    pin_edge_sync u_pin_sync
    (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_async (timer_input_pin),
        .edges     (pin_evt)
    );

    wire logic [1:0] cis = channel_mode_low.edge_sel;
    wire logic [2:0] sts = start_trigger_select;

    wire logic active_edge =
        (cis == `TMR_CIS_FALL) ? pin_evt.fall :                  // RL6
        (cis == `TMR_CIS_RISE) ? pin_evt.rise :                  // RL6
                                 pin_evt.rise | pin_evt.fall;    // RL7 RL8
    wire logic start_edge =
        (cis == `TMR_CIS_LOW_WIDTH)  ? pin_evt.fall :            // RL7
        (cis == `TMR_CIS_HIGH_WIDTH) ? pin_evt.rise :            // RL8
                                       active_edge;
    wire logic capture_edge =
        (cis == `TMR_CIS_LOW_WIDTH)  ? pin_evt.rise :            // RL7
        (cis == `TMR_CIS_HIGH_WIDTH) ? pin_evt.fall :            // RL8
                                       active_edge;

    // software-only select leaves both hardware terms at zero
    wire logic hw_start =
        (sts == `TMR_STS_PIN)        ? active_edge :               // RL2
        (sts == `TMR_STS_BOTH)       ? start_edge :                // RL3
        (sts == `TMR_STS_MASTER)     ? master_interrupt_request :  // RL4
        (sts == `TMR_STS_MASTER_PIN) ? master_interrupt_request :  // RL5
                                       1'b0;                       // RL1
    wire logic hw_capture =
        (sts == `TMR_STS_PIN)        ? active_edge :               // RL2
        (sts == `TMR_STS_BOTH)       ? capture_edge :              // RL3
        (sts == `TMR_STS_MASTER_PIN) ? active_edge :               // RL5
                                       1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // mode decode and start conditions

    wire logic [2:0] md  = channel_mode_low.mode[3:1];
    wire logic       opt = channel_mode_low.mode[0];

    wire logic is_interval = md == `TMR_MD_INTERVAL;
    wire logic is_capture  = md == `TMR_MD_CAPTURE;
    wire logic is_event    = md == `TMR_MD_EVENT;
    wire logic is_one      = md == `TMR_MD_ONE_COUNT;
    wire logic is_cap_one  = md == `TMR_MD_CAP_ONE;
    // two-input slave: capture mode, master starts it, own pin edge ends it
    wire logic slave_shot  = is_capture & (sts == `TMR_STS_MASTER_PIN);  // RL5
    wire logic one_shot    = is_one | is_cap_one | slave_shot;
    wire logic counts_up   = is_capture | is_cap_one;  // RL9 RL10

    wire logic trig_src  = (sts == `TMR_STS_SOFT) ? sw_start :           // RL1
                           hw_start & channel_enable_flag;
    wire logic retrig_ok = is_one & opt;                                 // RL13 RL14
    wire logic free_start = ~one_shot & sw_start & ~counting;
    wire logic shot_start = one_shot & trig_src & (~counting | retrig_ok);
    wire logic restart    = shot_start & counting;                       // RL14
    wire logic count_start = free_start | shot_start;

    // only interval and capture modes announce the start
    wire logic start_irq = count_start & ~restart & opt
                           & (is_interval | is_capture);                 // RL11 RL12

    wire logic cnt_zero = count_register == '0;

    ////////////////////////////////////////////////////////////////////////////
    // next-value logic

    logic                          next_end_irq;
    logic                          next_capture;
    logic [COUNT_WIDTH-1:0]        next_count;
    timer_pkg::channel_state_type  next_state;

    always_comb
    begin
        next_end_irq = 1'b0;
        next_capture = 1'b0;
        next_count   = count_register;
        next_state   = state;
        if (sw_stop)
        begin
            next_state = timer_pkg::CH_IDLE;                      // RL19
        end
        else if (count_start)
        begin
            next_state = timer_pkg::CH_COUNT;
            next_count = counts_up ? '0 : data_reg;               // RL9 RL10
        end
        else if (sw_start && one_shot && !channel_enable_flag)
        begin
            next_state = timer_pkg::CH_WAIT;                      // RL18
        end
        else if (counting)
        begin
            if (is_interval)
            begin
                next_end_irq = cnt_zero;
                next_count   = cnt_zero ? data_reg : count_register - 1'b1;
            end
            else if (is_event)
            begin
                if (active_edge)
                begin
                    next_end_irq = cnt_zero;
                    next_count   = cnt_zero ? data_reg : count_register - 1'b1;
                end
            end
            else if (is_one)
            begin
                next_end_irq = cnt_zero;
                next_count   = count_register - 1'b1;
                if (cnt_zero)
                begin
                    next_state = timer_pkg::CH_WAIT;
                    next_count = '0;
                end
            end
            else if (counts_up)
            begin
                next_count = count_register + 1'b1;               // RL9 RL10
                if (hw_capture)
                begin
                    next_end_irq = 1'b1;
                    next_capture = 1'b1;
                    next_count   = '0;
                    if (is_cap_one || slave_shot)
                    begin
                        next_state = timer_pkg::CH_WAIT;          // RL5 RL10
                    end
                end
                else if (is_capture && sts == `TMR_STS_BOTH && start_edge)
                begin
                    next_count = '0;                              // RL3
                end
            end
        end
    end

    // output toggles on every timer event; start counts only with option set
    wire logic toggle_evt = next_end_irq | start_irq;             // RL11

    ////////////////////////////////////////////////////////////////////////////
    // channel state

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state                     <= timer_pkg::CH_IDLE;
            count_register            <= '0;
            channel_interrupt_request <= 1'b0;
        end
        else
        begin
            state                     <= next_state;
            count_register            <= next_count;
            channel_interrupt_request <= next_end_irq | start_irq;
        end
    end

    // capture wins over a software write in the same cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            data_reg <= '0;
        else if (next_capture)
            data_reg <= count_register;
        else if (wr_data)
            data_reg <= data_written;
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and output level

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_trigger_select <= `TMR_RST_MODE_HIGH;
            channel_mode_low     <= `TMR_RST_MODE_LOW;
            output_enable_bit    <= `TMR_RST_OUT_ENABLE;
        end
        else
        begin
            if (wr_mhigh)
                start_trigger_select <= avs_writedata[2:0];
            if (wr_mlow)
                channel_mode_low <= avs_writedata[7:0];
            if (wr_oe)
                output_enable_bit <= avs_writedata[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            output_level_bit <= `TMR_RST_OUT_LEVEL;
        else if (output_enable_bit)
            output_level_bit <= output_level_bit ^ toggle_evt;   // RL16
        else if (wr_level)
            output_level_bit <= avs_writedata[0];                // RL15
    end

    // the level bit itself is the pin, so a read shows what the pin drives
    assign timer_output_pin = output_level_bit;                  // RL17

    ////////////////////////////////////////////////////////////////////////////
    // bus answer: one wait cycle on every access

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end
        else
        begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read && avs_waitrequest)
                avs_readdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sw_start;
        sw_start ##1 channel_enable_flag;
    endsequence

    sequence s_sw_stop;
        sw_stop ##1 !channel_enable_flag;
    endsequence

    property p_soft_only;
        (sts == `TMR_STS_SOFT) |-> !hw_start && !hw_capture;
    endproperty
    a_soft_only: assert property (p_soft_only)  // RL1
        else $error("hardware trigger seen with software-only select");

    property p_pin_trigger;
        (sts == `TMR_STS_PIN && cis == `TMR_CIS_RISE && pin_evt.rise)
            |-> hw_start && hw_capture;
    endproperty
    a_pin_trigger: assert property (p_pin_trigger)  // RL2
        else $error("pin edge not used as start and capture");

    property p_both_edges;
        (sts == `TMR_STS_BOTH && cis == `TMR_CIS_HIGH_WIDTH && pin_evt.fall)
            |-> hw_capture && !hw_start;
    endproperty
    a_both_edges: assert property (p_both_edges)  // RL3
        else $error("falling edge not taken as capture");

    property p_master_start;
        (sts == `TMR_STS_MASTER && master_interrupt_request) |-> hw_start;
    endproperty
    a_master_start: assert property (p_master_start)  // RL4
        else $error("master interrupt did not start slave");

    property p_fall_ignored;
        (sts == `TMR_STS_PIN && cis == `TMR_CIS_RISE && pin_evt.fall && !pin_evt.rise)
            |-> !hw_start;
    endproperty
    a_fall_ignored: assert property (p_fall_ignored)  // RL6
        else $error("falling edge accepted with rising select");

    property p_start_irq;
        (count_start && !restart && opt && is_interval) |=> channel_interrupt_request;
    endproperty
    a_start_irq: assert property (p_start_irq)  // RL11
        else $error("no interrupt at count start with option set");

    property p_no_start_irq;
        (count_start && !opt && is_interval && !cnt_zero && data_reg != '0)
            |=> !channel_interrupt_request;
    endproperty
    a_no_start_irq: assert property (p_no_start_irq)  // RL12
        else $error("interrupt at count start with option clear");

    property p_ignore_retrigger;
        (counting && is_one && !opt && hw_start && !cnt_zero && !sw_stop)
            |=> count_register == $past(count_register) - 1'b1;
    endproperty
    a_ignore_retrigger: assert property (p_ignore_retrigger)  // RL13
        else $error("one-count restarted with option clear");

    property p_retrigger;
        (restart && !sw_stop) |=> count_register == $past(data_reg)
                                  && !channel_interrupt_request;
    endproperty
    a_retrigger: assert property (p_retrigger)  // RL14
        else $error("retrigger did not reload quietly");

    property p_level_hold;
        (!output_enable_bit && !wr_level) |=> $stable(output_level_bit);
    endproperty
    a_level_hold: assert property (p_level_hold)  // RL15
        else $error("level changed with output disabled");

    property p_write_ignored;
        (output_enable_bit && wr_level && !toggle_evt) |=> $stable(output_level_bit);
    endproperty
    a_write_ignored: assert property (p_write_ignored)  // RL16
        else $error("level write taken with output enabled");

    property p_enable_set;
        (sw_start && !sw_stop) |-> s_sw_start;
    endproperty
    a_enable_set: assert property (p_enable_set)  // RL18
        else $error("start write did not set enable");

    property p_enable_clear;
        sw_stop |-> s_sw_stop;
    endproperty
    a_enable_clear: assert property (p_enable_clear)  // RL19
        else $error("stop write did not clear enable");

    property p_single_pulse;
        pin_evt.rise |=> !pin_evt.rise;
    endproperty
    a_single_pulse: assert property (p_single_pulse)  // RL20
        else $error("edge pulse longer than one cycle");

endmodule

// *** tb/pulse_source.sv ***
// external pulse source on the timer input pin
// assumes the bench spaces level changes by several core_clk cycles
module pulse_source
(
    // clock
    input  wire logic core_clk,
    // pin
    output      logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = 1'b0;
    // change just after an edge so each level is settled for whole cycles
    task automatic set_level(input logic v);
        @(posedge core_clk);
        pin <= v;
    endtask
endmodule

// *** tb/timer_channel_mode_and_output_bench.sv ***
// bench for one timer channel: avalon-mm master, pin source, interrupt counting
// assumes the registered one-wait-state bus and the register map of the header
`include "timer_consts.svh"
module timer_channel_mode_and_output_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        master_irq = 1'b0;
    logic        pin_in;
    logic        pin_out;
    logic        irq;
    logic [31:0] rd;
    int          miscompares = 0;
    int          n_checks = 0;
    int          n_irq = 0;
    // per pin case: trigger select, edge select, irqs on rise, irqs on fall
    int          sts_t [5] = '{0, 1, 1, 2, 2};
    int          cis_t [5] = '{1, 0, 1, 2, 3};
    int          rise_t [5] = '{0, 0, 1, 1, 0};
    int          fall_t [5] = '{0, 1, 0, 0, 1};
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (irq === 1'b1) n_irq++;
    end
    timer_channel dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_input_pin(pin_in),
        .master_interrupt_request(master_irq), .timer_output_pin(pin_out),
        .channel_interrupt_request(irq));
    pulse_source src (.core_clk(core_clk), .pin(pin_in));
    ////////////////////////////////////////////////////////////
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait; a missing pulse counts as a mismatch
    task automatic wait_irq(output longint t);
        int k;
        k = 0;
        @(posedge core_clk);
        while (irq !== 1'b1 && k < 200)
        begin
            @(posedge core_clk);
            k++;
        end
        t = $time / 20;
        if (k >= 200)
        begin
            miscompares++;
            $display("Error %0t: no interrupt within 200 cycles", $time);
        end
    endtask
    task automatic pulse_master(output longint t);
        @(posedge core_clk);
        master_irq <= 1'b1;
        t = $time / 20;
        @(posedge core_clk);
        master_irq <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        longint ts, t0, t1, tp1, tp2, lat0;
        int d, n0;
        logic p0;
        void'($urandom(32'h3e05d654));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        idle(2);
        bus(0, `TMR_OFS_MODE_LOW, 0); check(rd, 32'h0);
        bus(0, `TMR_OFS_OUT_ENABLE, 0); check(rd, 32'h0);
        bus(0, 6'h3c, 0); check(rd, 32'h0);
        bus(1, `TMR_OFS_OUT_LEVEL, 1); idle(2); check(pin_out, 1);
        bus(0, `TMR_OFS_OUT_LEVEL, 0); check(rd, 1);
        bus(1, `TMR_OFS_OUT_LEVEL, 0); idle(2); check(pin_out, 0);
        bus(1, `TMR_OFS_OUT_ENABLE, 1);
        bus(1, `TMR_OFS_OUT_LEVEL, 1); idle(2); check(pin_out, 0);
        // interval timer, option 1 then option 0, random reload
        d = 3 + $urandom % 6;
        bus(1, `TMR_OFS_DATA, d);
        bus(1, `TMR_OFS_MODE_LOW, 32'h01);
        bus(1, `TMR_OFS_START, 1);
        ts = $time / 20;
        wait_irq(t0); check(t0 - ts <= 3, 1);
        idle(2);
        p0 = pin_out;
        wait_irq(t1); check(t1 - t0, d + 1);
        idle(2); check(pin_out, !p0);
        bus(0, `TMR_OFS_STATUS, 0); check(rd[0], 1);
        bus(1, `TMR_OFS_STOP, 1);
        bus(0, `TMR_OFS_STATUS, 0); check(rd[0], 0);
        n0 = n_irq; idle(20); check(n_irq - n0, 0);
        bus(1, `TMR_OFS_MODE_LOW, 32'h00);
        bus(1, `TMR_OFS_START, 1);
        ts = $time / 20;
        wait_irq(t0); check(t0 - ts > 3, 1);
        // capture mode: which pin edges capture under each select pair
        for (int i = 0; i < 5; i++)
        begin
            bus(1, `TMR_OFS_STOP, 1);
            bus(1, `TMR_OFS_MODE_HIGH, sts_t[i]);
            bus(1, `TMR_OFS_MODE_LOW, {cis_t[i][1:0], 6'h04});
            bus(1, `TMR_OFS_START, 1);
            idle(4);
            n0 = n_irq; src.set_level(1); idle(10);
            check(n_irq - n0, rise_t[i]);
            n0 = n_irq; src.set_level(0); idle(10);
            check(n_irq - n0, fall_t[i]);
        end
        // two-input slave: pin ignored until the master starts it, then a rise ends it
        bus(1, `TMR_OFS_STOP, 1);
        bus(1, `TMR_OFS_MODE_HIGH, `TMR_STS_MASTER_PIN);
        bus(1, `TMR_OFS_MODE_LOW, 32'h44);
        bus(1, `TMR_OFS_START, 1);
        for (int k = 0; k < 2; k++)
        begin
            if (k == 1) pulse_master(tp1);
            n0 = n_irq; src.set_level(1); idle(10); src.set_level(0); idle(6);
            check(n_irq - n0, k);
        end
        bus(0, `TMR_OFS_DATA, 0); check(rd, 4);
        // capture and one-count: rise starts, fall captures the high width
        bus(1, `TMR_OFS_MODE_HIGH, `TMR_STS_PIN);
        bus(1, `TMR_OFS_MODE_LOW, 32'hcc);
        bus(1, `TMR_OFS_START, 1);
        n0 = n_irq; src.set_level(1); idle(5); src.set_level(0); idle(10);
        check(n_irq - n0, 1);
        bus(0, `TMR_OFS_DATA, 0); check(rd, 5);
        // one-count slave started by master interrupt, retriggered mid-count
        for (int opt = 0; opt < 2; opt++)
        begin
            bus(1, `TMR_OFS_STOP, 1);
            bus(1, `TMR_OFS_MODE_HIGH, `TMR_STS_MASTER);
            bus(1, `TMR_OFS_DATA, 10);
            bus(1, `TMR_OFS_MODE_LOW, 32'h08 | opt);
            bus(1, `TMR_OFS_START, 1);
            idle(3);
            n0 = n_irq;
            pulse_master(tp1); idle(3); pulse_master(tp2);
            wait_irq(t0); idle(25);
            check(n_irq - n0, 1);
            if (opt == 0) lat0 = t0 - tp1;
            else check(t0 - tp1 - lat0, tp2 - tp1);
        end
        print_verdict();
    end
endmodule
